// ===== sim/mnr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module mnr_host_model
  import mnr_pkg::*;
(
  // Clock and read answer
  input  wire logic       clk_i,
  input  wire logic       rd_valid_i,
  input  wire logic [7:0] rd_byte_i,
  // Protocol engine strobes
  output logic            cmd_valid_o,
  output logic [7:0]      cmd_code_o,
  output logic            cmd_read_o,
  output logic            txn_end_o,
  output logic            wr_valid_o,
  output logic [7:0]      wr_byte_o,
  output logic            rd_req_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o  = 8'h00;
    cmd_read_o  = 1'b0;
    txn_end_o   = 1'b0;
    wr_valid_o  = 1'b0;
    wr_byte_o   = 8'h00;
    rd_req_o    = 1'b0;
  end

  // Released lines show the inverse so a stale value never passes
  task automatic send_cmd(input logic [7:0] code, input logic rd);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o  = code;
    cmd_read_o  = rd;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_code_o  = ~code;
    cmd_read_o  = ~rd;
  endtask : send_cmd

  task automatic end_txn();
    @(negedge clk_i);
    txn_end_o = 1'b1;
    @(negedge clk_i);
    txn_end_o = 1'b0;
  endtask : end_txn

  // Count byte, then n data bytes low byte first; short or bad counts are deliberate faults
  task automatic blk_write(input logic [7:0] code, input logic [7:0] cnt,
                           input logic [23:0] val, input int n);
    logic [31:0] frame;
    frame = {val, cnt};
    send_cmd(code, 1'b0);
    for (int i = 0; i <= n; i++) begin
      @(negedge clk_i);
      wr_valid_o = 1'b1;
      wr_byte_o  = frame[8*i +: 8];
      @(negedge clk_i);
      wr_valid_o = 1'b0;
      wr_byte_o  = ~frame[8*i +: 8];
    end
    end_txn();
  endtask : blk_write

  // Four requests: count then three data bytes
  task automatic blk_read(input logic [7:0] code, output logic [31:0] got);
    got = 32'hFFFF_FFFF;
    send_cmd(code, 1'b1);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      rd_req_o = 1'b1;
      // The answer is a one-cycle pulse launched by the edge that took the request
      @(negedge clk_i);
      if (rd_valid_i === 1'b1) begin
        got[8*i +: 8] = rd_byte_i;
      end
      rd_req_o = 1'b0;
    end
    end_txn();
  endtask : blk_read
endmodule : mnr_host_model
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import mnr_pkg::*;
;
  logic        clk, srst, cmd_valid, cmd_read, txn_end, wr_valid, rd_req, rd_valid;
  logic        ack, wr_err, nvm_load;
  logic [7:0]  cmd_code, wr_byte, rd_byte;
  logic [23:0] img [3];
  logic [23:0] outs [3];
  logic [7:0]  codes [3];
  logic [31:0] got;
  int          n_fail, checks, n_err;

  mnr_info_regs dut (.CLOCK_I(clk), .SRST_I(srst), .CMD_VALID_I(cmd_valid),
    .CMD_CODE_I(cmd_code), .CMD_READ_I(cmd_read), .TXN_END_I(txn_end),
    .WR_BYTE_VALID_I(wr_valid), .WR_BYTE_I(wr_byte), .RD_BYTE_REQ_I(rd_req),
    .RD_BYTE_VALID_O(rd_valid), .RD_BYTE_O(rd_byte), .CMD_ACK_O(ack), .WR_ERR_O(wr_err),
    .NVM_LOAD_I(nvm_load), .NVM_MAKER_ID_I(img[0]), .NVM_MODEL_I(img[1]),
    .NVM_REVISION_I(img[2]), .MAKER_ID_O(outs[0]), .MODEL_O(outs[1]), .REVISION_O(outs[2]));

  mnr_host_model host (.clk_i(clk), .rd_valid_i(rd_valid), .rd_byte_i(rd_byte),
    .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .cmd_read_o(cmd_read),
    .txn_end_o(txn_end), .wr_valid_o(wr_valid), .wr_byte_o(wr_byte), .rd_req_o(rd_req));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (wr_err === 1'b1) begin
      n_err++;
    end
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    #160000;
    n_fail++;
    final_report();
  end

  initial begin
    codes = '{CMD_MAKER_ID, CMD_MODEL, CMD_REVISION};
    img = '{24'h12_3456, 24'hA1_B2C3, 24'h0F_1E2D};
    srst = 1'b1;
    nvm_load = 1'b0;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 3; i++) begin
      check({8'h00, outs[i]}, {8'h00, img[i]});
      host.blk_read(codes[i], got);
      check(got, {img[i], BLOCK_COUNT});
    end
    for (int i = 0; i < 3; i++) begin
      host.blk_write(codes[i], BLOCK_COUNT, ~img[i], INFO_BYTES);
      repeat (2) @(posedge clk);
      #1;
      check({31'h0, ack}, 32'h1);
      check({8'h00, outs[i]}, {8'h00, ~img[i]});
      host.blk_read(codes[i], got);
      check(got, {~img[i], BLOCK_COUNT});
    end
    // Bad count, then short payload: both refused
    host.blk_write(CMD_MODEL, 8'h02, 24'h00_1111, 2);
    host.blk_write(CMD_MODEL, BLOCK_COUNT, 24'h00_2222, 2);
    repeat (2) @(posedge clk);
    #1;
    check(n_err, 2);
    check({8'h00, outs[1]}, {8'h00, ~img[1]});
    // Neighbouring unknown code must not touch the shared copies
    host.blk_write(8'h9C, BLOCK_COUNT, 24'h00_0000, INFO_BYTES);
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, ack}, 32'h0);
    check({8'h00, outs[2]}, {8'h00, ~img[2]});
    @(negedge clk);
    img = '{24'h55_AA00, 24'h00_FF33, 24'hC3_3C99};
    nvm_load = 1'b1;
    @(negedge clk);
    nvm_load = 1'b0;
    for (int i = 0; i < 3; i++) begin
      check({8'h00, outs[i]}, {8'h00, img[i]});
    end
    final_report();
  end
endmodule : testbench
`default_nettype wire

// ===== verilog/mnr_info_cell.sv
`timescale 1ns/10ps
`default_nettype none
module mnr_info_cell
  import mnr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  // Nonvolatile image load
  input  wire logic              load_i,
  input  wire logic [INFO_W-1:0] load_val_i,
  // Host write
  input  wire logic              wr_en_i,
  input  wire logic [INFO_W-1:0] wr_val_i,
  // Stored value
  output logic      [INFO_W-1:0] val_o
);

  typedef struct packed {
    logic [INFO_W-1:0] val;
  } mnr_cell_t;

  mnr_cell_t cell_reg;
  mnr_cell_t cell_next;

  always_comb begin
    cell_next = cell_reg;
    // The nonvolatile image is the power-up value and wins over a host write
    if (srst_i || load_i) begin
      cell_next.val = load_val_i;
    end else if (wr_en_i) begin
      cell_next.val = wr_val_i;
    end
  end

  always_ff @(posedge clk_i) begin
    cell_reg <= cell_next;
  end

  assign val_o = cell_reg.val;

endmodule : mnr_info_cell
`default_nettype wire

// ===== verilog/mnr_info_regs.sv
// Summary of operation
// [R1] Model register answers code 9Ah with block write and block read.
// [R2] Revision register answers code 9Bh, block write and read of three bytes.
// [R3] Identification register holds 24 bits, any content, reset value from NVM.
// [R4] Model register holds 24 read/write bits, initialised from NVM.
// [R5] Revision register holds 24 read/write bits, initialised from NVM.
// [R6] Each value travels as a 3-byte unsigned binary block payload.
// [R7] One shared copy for all channels, page ignored, backed by EEPROM.
// [R8] Block read returns count three then data bytes, least significant first.
`timescale 1ns/10ps
`default_nettype none
module mnr_info_regs
  import mnr_pkg::*;
(
  // Clock and reset
  input  wire logic              CLOCK_I,
  input  wire logic              SRST_I,
  // Command from the bus protocol engine
  input  wire logic              CMD_VALID_I,
  input  wire logic [7:0]        CMD_CODE_I,
  input  wire logic              CMD_READ_I,
  input  wire logic              TXN_END_I,
  // Block write byte stream
  input  wire logic              WR_BYTE_VALID_I,
  input  wire logic [7:0]        WR_BYTE_I,
  // Block read byte stream
  input  wire logic              RD_BYTE_REQ_I,
  output logic                   RD_BYTE_VALID_O,
  output logic      [7:0]        RD_BYTE_O,
  // Status
  output logic                   CMD_ACK_O,
  output logic                   WR_ERR_O,
  // Nonvolatile image and stored values
  input  wire logic              NVM_LOAD_I,
  input  wire logic [INFO_W-1:0] NVM_MAKER_ID_I,
  input  wire logic [INFO_W-1:0] NVM_MODEL_I,
  input  wire logic [INFO_W-1:0] NVM_REVISION_I,
  output logic      [INFO_W-1:0] MAKER_ID_O,
  output logic      [INFO_W-1:0] MODEL_O,
  output logic      [INFO_W-1:0] REVISION_O
);

  typedef struct packed {
    mnr_state_t        state;
    logic [1:0]        sel;
    logic [2:0]        cnt;
    logic              count_ok;
    logic [INFO_W-1:0] buffer;
    logic              commit;
    logic              rd_valid;
    logic [7:0]        rd_byte;
    logic              ack;
    logic              err;
  } mnr_ctl_t;

  mnr_ctl_t ctl_reg;
  mnr_ctl_t ctl_next;

  logic [INFO_W-1:0] nvm_val  [NUM_REGS];
  logic [INFO_W-1:0] info_val [NUM_REGS];
  logic              hit;
  logic [1:0]        hit_idx;
  logic [INFO_W-1:0] sel_val;

  assign nvm_val[0] = NVM_MAKER_ID_I;
  assign nvm_val[1] = NVM_MODEL_I;
  assign nvm_val[2] = NVM_REVISION_I;

  // Page selection is deliberately not an input: one copy serves every channel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_cell
      mnr_info_cell u_cell (
        .clk_i      (CLOCK_I),
        .srst_i     (SRST_I),
        .load_i     (NVM_LOAD_I),
        .load_val_i (nvm_val[gi]),
        .wr_en_i    (ctl_reg.commit && (ctl_reg.sel == 2'(gi))),
        .wr_val_i   (ctl_reg.buffer),
        .val_o      (info_val[gi])
      ); // R3 R4 R5 R7
    end
  endgenerate

  always_comb begin
    hit     = 1'b1;
    hit_idx = IDX_MAKER_ID;
    case (CMD_CODE_I)
      CMD_MAKER_ID: hit_idx = IDX_MAKER_ID;
      CMD_MODEL:    hit_idx = IDX_MODEL; // R1
      CMD_REVISION: hit_idx = IDX_REVISION; // R2
      default:      hit     = 1'b0;
    endcase
  end

  assign sel_val = info_val[ctl_reg.sel];

  always_comb begin
    ctl_next          = ctl_reg;
    ctl_next.commit   = 1'b0;
    ctl_next.rd_valid = 1'b0;
    ctl_next.err      = 1'b0;
    if (CMD_VALID_I) begin
      // A new command always restarts the sequence, as after a repeated start
      ctl_next.ack      = hit;
      ctl_next.sel      = hit_idx;
      ctl_next.cnt      = 3'h0;
      ctl_next.count_ok = 1'b0;
      if (!hit) begin
        ctl_next.state = ST_IDLE;
      end else if (CMD_READ_I) begin
        ctl_next.state = ST_RD;
      end else begin
        ctl_next.state = ST_WR;
      end
    end else begin
      case (ctl_reg.state)
        ST_IDLE: begin
          ctl_next.state = ST_IDLE;
        end
        ST_WR: begin
          if (TXN_END_I) begin
            // Short, long or miscounted blocks leave the stored value untouched
            if (ctl_reg.count_ok && (ctl_reg.cnt == CNT_OVER)) begin
              ctl_next.commit = 1'b1; // R6
            end else begin
              ctl_next.err = 1'b1;
            end
            ctl_next.state = ST_IDLE;
          end else if (WR_BYTE_VALID_I) begin
            case (ctl_reg.cnt)
              3'h0: ctl_next.count_ok = (WR_BYTE_I == BLOCK_COUNT); // R6
              3'h1: ctl_next.buffer[7:0]   = WR_BYTE_I;
              3'h2: ctl_next.buffer[15:8]  = WR_BYTE_I;
              3'h3: ctl_next.buffer[23:16] = WR_BYTE_I;
              default: ctl_next.count_ok = 1'b0;
            endcase
            if (ctl_reg.cnt != CNT_OVER) begin
              ctl_next.cnt = ctl_reg.cnt + 3'h1;
            end
          end
        end
        ST_RD: begin
          if (TXN_END_I) begin
            ctl_next.state = ST_IDLE;
          end else if (RD_BYTE_REQ_I) begin
            ctl_next.rd_valid = 1'b1;
            case (ctl_reg.cnt)
              3'h0:    ctl_next.rd_byte = BLOCK_COUNT; // R8
              3'h1:    ctl_next.rd_byte = sel_val[7:0]; // R8
              3'h2:    ctl_next.rd_byte = sel_val[15:8];
              3'h3:    ctl_next.rd_byte = sel_val[23:16];
              default: ctl_next.rd_byte = RD_PAD_BYTE;
            endcase
            if (ctl_reg.cnt != CNT_OVER) begin
              ctl_next.cnt = ctl_reg.cnt + 3'h1;
            end
          end
        end
        default: begin
          ctl_next.state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      ctl_reg <= '{state: ST_IDLE, sel: IDX_MAKER_ID, cnt: 3'h0, count_ok: 1'b0,
                   buffer: '0, commit: 1'b0, rd_valid: 1'b0, rd_byte: 8'h00,
                   ack: 1'b0, err: 1'b0};
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign RD_BYTE_VALID_O = ctl_reg.rd_valid;
  assign RD_BYTE_O       = ctl_reg.rd_byte;
  assign CMD_ACK_O       = ctl_reg.ack;
  assign WR_ERR_O        = ctl_reg.err;
  assign MAKER_ID_O      = info_val[0];
  assign MODEL_O         = info_val[1];
  assign REVISION_O      = info_val[2];

  // Checks

  property p_model_code;
    @(posedge CLOCK_I) disable iff (SRST_I)
      CMD_VALID_I && (CMD_CODE_I == CMD_MODEL) |=> CMD_ACK_O && (ctl_reg.sel == IDX_MODEL);
  endproperty
  a_model_code: assert property (p_model_code) else $error("model code not taken"); // R1

  property p_rev_code;
    @(posedge CLOCK_I) disable iff (SRST_I)
      CMD_VALID_I && (CMD_CODE_I == CMD_REVISION) |=> CMD_ACK_O && (ctl_reg.sel == IDX_REVISION);
  endproperty
  a_rev_code: assert property (p_rev_code) else $error("revision code not taken"); // R2

  property p_nvm_load;
    @(posedge CLOCK_I)
      NVM_LOAD_I |=> (MAKER_ID_O == $past(NVM_MAKER_ID_I)) && (MODEL_O == $past(NVM_MODEL_I))
                     && (REVISION_O == $past(NVM_REVISION_I));
  endproperty
  a_nvm_load: assert property (p_nvm_load) else $error("nonvolatile image not loaded"); // R3

  property p_model_write;
    @(posedge CLOCK_I) disable iff (SRST_I)
      ctl_reg.commit && (ctl_reg.sel == IDX_MODEL) && !NVM_LOAD_I
        |=> MODEL_O == $past(ctl_reg.buffer);
  endproperty
  a_model_write: assert property (p_model_write) else $error("model write lost"); // R4

  property p_rev_hold;
    @(posedge CLOCK_I) disable iff (SRST_I)
      !(ctl_reg.commit && (ctl_reg.sel == IDX_REVISION)) && !NVM_LOAD_I |=> $stable(REVISION_O);
  endproperty
  a_rev_hold: assert property (p_rev_hold) else $error("revision changed unasked"); // R5

  property p_bad_count;
    @(posedge CLOCK_I) disable iff (SRST_I)
      (ctl_reg.state == ST_WR) && TXN_END_I && !CMD_VALID_I && !ctl_reg.count_ok
        |=> WR_ERR_O && !ctl_reg.commit;
  endproperty
  a_bad_count: assert property (p_bad_count) else $error("bad block count committed"); // R6

  property p_read_count;
    @(posedge CLOCK_I) disable iff (SRST_I)
      (ctl_reg.state == ST_RD) && (ctl_reg.cnt == 3'h0) && RD_BYTE_REQ_I
      && !TXN_END_I && !CMD_VALID_I
        |=> RD_BYTE_VALID_O && (RD_BYTE_O == BLOCK_COUNT);
  endproperty
  a_read_count: assert property (p_read_count) else $error("block count byte wrong"); // R8

  property p_read_lsb;
    @(posedge CLOCK_I) disable iff (SRST_I)
      (ctl_reg.state == ST_RD) && (ctl_reg.cnt == 3'h1) && RD_BYTE_REQ_I
      && !TXN_END_I && !CMD_VALID_I
        |=> RD_BYTE_VALID_O && (RD_BYTE_O == $past(sel_val[7:0]));
  endproperty
  a_read_lsb: assert property (p_read_lsb) else $error("first data byte not lsb"); // R8

  property p_shared_copy;
    @(posedge CLOCK_I) disable iff (SRST_I)
      ctl_reg.commit && (ctl_reg.sel == IDX_MAKER_ID) && !NVM_LOAD_I
        |=> (MAKER_ID_O == $past(ctl_reg.buffer)) && $stable(MODEL_O);
  endproperty
  a_shared_copy: assert property (p_shared_copy) else $error("shared copy not written"); // R7

endmodule : mnr_info_regs
`default_nettype wire

// ===== verilog/mnr_pkg.sv
package mnr_pkg;

  // Command codes answered by this bank
  localparam logic [7:0]  CMD_MAKER_ID   = 8'h99;
  localparam logic [7:0]  CMD_MODEL      = 8'h9A;
  localparam logic [7:0]  CMD_REVISION   = 8'h9B;

  // Block payload layout
  localparam int          INFO_W         = 24;
  localparam int          INFO_BYTES     = 3;
  localparam logic [7:0]  BLOCK_COUNT    = 8'h03;
  localparam logic [7:0]  RD_PAD_BYTE    = 8'hFF;
  localparam logic [2:0]  CNT_LAST       = 3'h3;
  localparam logic [2:0]  CNT_OVER       = 3'h4;

  // Register index inside the bank
  localparam logic [1:0]  IDX_MAKER_ID   = 2'h0;
  localparam logic [1:0]  IDX_MODEL      = 2'h1;
  localparam logic [1:0]  IDX_REVISION   = 2'h2;
  localparam int          NUM_REGS       = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WR   = 3'b010,
    ST_RD   = 3'b100
  } mnr_state_t;

endpackage : mnr_pkg
